// ==== hw/rsc_top.sv ====
// rsc_top: reset source control with supply drop filter, threshold code
// check, flash key reset, watchdog expiry handling and ahb-lite registers
// assumes all inputs synchronous to i_clk_sys; supply compare comes from
// the analog comparator already referenced to o_threshold_code
//
// How it works
// - supply drop below threshold resets, sets flag
// - ignore drops shorter than filter time
// - four threshold codes select four voltages
// - undefined code resets after fault delay
// - code fault reset restores threshold power-on value
// - supply drop reset keeps threshold contents
// - threshold register powers up at 55h
// - monitor off in idle or sleep
// - supply drop flag bit 2, software clears
// - code fault flag bit 1, software clears
// - cause bits 7 to 4 read zero
// - writing 55h to flash control resets
// - watchdog expiry running: full reset, expiry flag
// - watchdog expiry asleep: clear pc, sp only
// - status flags set per reset source
// - power-on: pc zero, irqs off, sp top
// - power-on: wdt restart, timers off, ports input
// - guard register fault sets flag bit 3
`timescale 1ns/1ns
`include "rsc_cfg.svh"
module rsc_top
    import rsc_pkg::*;
#(
    parameter int unsigned FILTER_CYC = `RSC_FILTER_CYC, // supply drop filter
    parameter int unsigned FAULT_CYC  = `RSC_FAULT_CYC   // code fault delay
) (
    input  wire logic          i_clk_sys,
    input  wire logic          i_resetn,
    input  wire logic          i_ce,
    input  wire rsc_ahb_req_t  i_ahb,
    input  wire logic          i_supply_low,
    input  wire rsc_pwr_mode_t i_pwr_mode,
    input  wire logic          i_pin_clear,
    input  wire logic          i_wdt_expiry,
    input  wire logic          i_wdt_code_fault,
    input  wire logic          i_guard_fault,
    output rsc_ahb_rsp_t       o_ahb,
    output logic               o_dev_reset,
    output rsc_init_t          o_init,
    output logic               o_monitor_en,
    output logic [7:0]         o_threshold_code,
    output logic               o_wdt_expiry_flag,
    output logic               o_powerdown_flag,
    output logic               o_irq
);
    localparam int CW = `RSC_CNT_W;
    localparam int NE = `RSC_NUM_EV;

    // whole state of the block
    typedef struct packed {
        rsc_state_t        st;        // sequencer state
        logic [3:0]        hold_cnt;  // cycles of reset left
        logic [7:0]        thresh;    // supply threshold select
        logic [3:0]        cause;     // cause flags
        logic              to_flag;   // watchdog expiry flag
        logic              pd_flag;   // powerdown flag
        logic [CW-1:0]     filt_cnt;  // supply low duration
        logic [CW-1:0]     fault_cnt; // undefined code duration
        logic [NE-1:0]     irq_stat;  // sticky events
        logic [NE-1:0]     irq_en;    // event enables
        logic              irq;       // interrupt line
        rsc_init_t         init;      // initial condition strobes
        logic              dev_reset; // full device reset
        logic              mon_en;    // supply monitor enable
        logic              ahb_act;   // data phase pending
        logic              ahb_wr;    // pending transfer is a write
        logic              ahb_map;   // upper address bits zero
        logic [7:0]        ahb_addr;  // pending byte offset
        rsc_ahb_rsp_t      rsp;       // bus answer
    } rsc_regs_t;

    rsc_regs_t q;
    rsc_regs_t d;

    // one of the four defined threshold codes
    function automatic logic code_valid(input logic [7:0] c);
        return (c == `RSC_CODE_2V10) || (c == `RSC_CODE_2V55) ||
               (c == `RSC_CODE_3V15) || (c == `RSC_CODE_3V80);
    endfunction

    // idle or sleep
    function automatic logic low_power(input rsc_pwr_mode_t m);
        return (m == RSC_PM_IDLE) || (m == RSC_PM_SLEEP);
    endfunction

    // register read mux, reserved and unmapped read zero
    function automatic logic [31:0] rd_mux(input rsc_regs_t s);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (!s.ahb_map) begin
            v = 32'h0000_0000;
        end else if (s.ahb_addr == `RSC_OFF_THRESH) begin
            v = {24'h00_0000, s.thresh};
        end else if (s.ahb_addr == `RSC_OFF_CAUSE) begin
            v = {28'h000_0000, s.cause};
        end else if (s.ahb_addr == `RSC_OFF_STATUS) begin
            v = {30'h0, s.pd_flag, s.to_flag};
        end else if (s.ahb_addr == `RSC_OFF_IRQ_STAT) begin
            v = {27'h0, s.irq_stat};
        end else if (s.ahb_addr == `RSC_OFF_IRQ_EN) begin
            v = {27'h0, s.irq_en};
        end
        return v;
    endfunction

    // decoded events, visible to the assertions
    logic wr_now;
    logic lvr_hit;
    logic fault_hit;
    logic iap_hit;
    logic wdt_run;
    logic wdt_low;
    logic full_req;

    // next state
    always_comb begin
        d = q;
        // data phase write this cycle
        wr_now = q.ahb_act && q.ahb_wr && q.ahb_map;
        // supply drop lasting longer than the filter time
        lvr_hit = (q.st == RSC_ST_RUN) && q.mon_en && i_supply_low &&
                  (q.filt_cnt >= CW'(FILTER_CYC));
        // undefined threshold code persisting through the fault delay
        fault_hit = (q.st == RSC_ST_RUN) && !code_valid(q.thresh) &&
                    (q.fault_cnt >= CW'(FAULT_CYC - 1));
        iap_hit = wr_now && (q.ahb_addr == `RSC_OFF_FLASH1) &&
                  (i_ahb.hwdata[7:0] == `RSC_IAP_KEY);
        wdt_run = i_wdt_expiry && !low_power(i_pwr_mode);
        wdt_low = i_wdt_expiry && low_power(i_pwr_mode);
        full_req = lvr_hit || fault_hit || iap_hit || i_pin_clear || wdt_run ||
                   i_guard_fault || i_wdt_code_fault;

        // monitor follows power mode
        d.mon_en = !low_power(i_pwr_mode);

        // filter counters, saturating; cleared outside run
        if (q.st == RSC_ST_RUN && q.mon_en && i_supply_low) begin
            if (q.filt_cnt != {CW{1'b1}}) begin
                d.filt_cnt = q.filt_cnt + CW'(1);
            end
        end else begin
            d.filt_cnt = '0;
        end
        if (q.st == RSC_ST_RUN && !code_valid(q.thresh)) begin
            if (q.fault_cnt != {CW{1'b1}}) begin
                d.fault_cnt = q.fault_cnt + CW'(1);
            end
        end else begin
            d.fault_cnt = '0;
        end

        // software writes
        if (wr_now) begin
            if (q.ahb_addr == `RSC_OFF_THRESH) begin
                d.thresh = i_ahb.hwdata[7:0];
            end else if (q.ahb_addr == `RSC_OFF_CAUSE) begin
                // only zeros act: software may clear, never set
                d.cause = q.cause & i_ahb.hwdata[3:0];
            end else if (q.ahb_addr == `RSC_OFF_IRQ_CLR) begin
                d.irq_stat = q.irq_stat & ~i_ahb.hwdata[NE-1:0];
            end else if (q.ahb_addr == `RSC_OFF_IRQ_EN) begin
                d.irq_en = i_ahb.hwdata[NE-1:0];
            end
        end

        // hardware sets win over software clears
        if (lvr_hit) begin
            d.cause[`RSC_BIT_SUPPLY_DROP_CAUSE_FLAG] = 1'b1;
        end
        if (fault_hit) begin
            d.cause[`RSC_BIT_LRF] = 1'b1;
        end
        if (i_guard_fault && q.st == RSC_ST_RUN) begin
            d.cause[`RSC_BIT_CONTROL_CODE_FAULT_FLAG] = 1'b1;
        end
        if (i_wdt_code_fault && q.st == RSC_ST_RUN) begin
            d.cause[`RSC_BIT_WDCODE] = 1'b1;
        end

        // reset sequencer
        case (q.st)
            RSC_ST_RUN: begin
                if (full_req) begin
                    // full reset, same conditions as power-on
                    d.st        = RSC_ST_HOLD;
                    d.hold_cnt  = 4'(`RSC_HOLD_CYC - 1);
                    d.dev_reset = 1'b1;
                    d.init      = '1;
                    if (fault_hit) begin
                        d.thresh = `RSC_THRESH_POR;
                    end else if (lvr_hit) begin
                        d.thresh = q.thresh;
                    end else begin
                        d.thresh = `RSC_THRESH_POR;
                    end
                    if (wdt_run) begin
                        d.to_flag = 1'b1;
                    end
                end else if (wdt_low) begin
                    // warm restart: only pc and sp, rest untouched
                    d.st            = RSC_ST_HOLD;
                    d.hold_cnt      = 4'(`RSC_HOLD_CYC - 1);
                    d.init.pc_zero  = 1'b1;
                    d.init.sp_reset = 1'b1;
                    d.to_flag       = 1'b1;
                    d.pd_flag       = 1'b1;
                end
            end
            RSC_ST_HOLD: begin
                // requests arriving now are absorbed by this reset
                if (q.hold_cnt == 4'h0) begin
                    d.st        = RSC_ST_RUN;
                    d.dev_reset = 1'b0;
                    d.init      = '0;
                end else begin
                    d.hold_cnt = q.hold_cnt - 4'h1;
                end
            end
            default: begin
                d.st = RSC_ST_RUN;
            end
        endcase

        // sticky events; set wins over clear
        d.irq_stat = d.irq_stat |
                     {iap_hit, i_wdt_expiry, i_guard_fault, fault_hit, lvr_hit};
        d.irq = |(d.irq_stat & d.irq_en);

        // bus slave: one wait state, answer always okay
        d.rsp.hresp = 1'b0;
        if (q.ahb_act) begin
            d.ahb_act       = 1'b0;
            d.rsp.hreadyout = 1'b1;
            d.rsp.hrdata    = q.ahb_wr ? 32'h0000_0000 : rd_mux(q);
        end
        if (i_ahb.hsel && i_ahb.htrans[1] && i_ahb.hready) begin
            d.ahb_act       = 1'b1;
            d.ahb_wr        = i_ahb.hwrite;
            d.ahb_map       = (i_ahb.haddr[31:8] == 24'h00_0000);
            d.ahb_addr      = i_ahb.haddr[7:0];
            d.rsp.hreadyout = 1'b0;
        end
    end

    // state register; reset is the power-on reset
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            q           <= '0;
            q.st        <= RSC_ST_HOLD;
            q.hold_cnt  <= 4'(`RSC_HOLD_CYC - 1);
            q.thresh    <= `RSC_THRESH_POR;
            q.init      <= '1;
            q.dev_reset <= 1'b1;
            q.to_flag   <= 1'b0;
            q.pd_flag   <= 1'b0;
            q.mon_en    <= 1'b1;
            q.rsp       <= '{hrdata: 32'h0000_0000, hreadyout: 1'b1, hresp: 1'b0};
        end else if (i_ce) begin
            q <= d;
        end
    end

    // outputs straight from flops
    assign o_ahb             = q.rsp;
    assign o_dev_reset       = q.dev_reset;
    assign o_init            = q.init;
    assign o_monitor_en      = q.mon_en;
    assign o_threshold_code  = q.thresh;
    assign o_wdt_expiry_flag = q.to_flag;
    assign o_powerdown_flag  = q.pd_flag;
    assign o_irq             = q.irq;

    // checks; frozen cycles and reset excluded
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn || !i_ce);

    // full reset lasts exactly two cycles
    hold_len_a: assert property ($rose(o_dev_reset) |-> o_dev_reset[*2] ##1 !o_dev_reset)
        else $error("device reset length wrong");
    // monitor disabled in low power
    mon_off_a: assert property (low_power(i_pwr_mode) |=> !o_monitor_en)
        else $error("monitor active in idle or sleep");
    // filtered drop resets and flags
    lvr_flag_a: assert property (lvr_hit |=> o_dev_reset && q.cause[2])
        else $error("supply drop not acted on");
    // a drop needs supply low and monitor on in the cycle before
    short_drop_a: assert property (lvr_hit |-> $past(i_supply_low) && $past(o_monitor_en))
        else $error("reset on short supply drop");
    // code fault restores power-on code and flags
    code_fault_a: assert property (fault_hit |=> q.cause[1] && o_threshold_code == 8'h55)
        else $error("code fault handling wrong");
    // age of an undefined code in run, counted apart from the fault counter
    // so a late fault reset cannot hide behind the design's own count
    logic [CW-1:0] bad_age;
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn || q.st != RSC_ST_RUN || code_valid(o_threshold_code)) begin
            bad_age <= '0;
        end else if (i_ce && bad_age != {CW{1'b1}}) begin
            bad_age <= bad_age + CW'(1);
        end
    end
    // undefined code never outlives the fault delay
    code_wait_a: assert property (bad_age <= CW'(FAULT_CYC))
        else $error("undefined code not caught");
    // supply drop keeps the threshold
    keep_thresh_a: assert property (lvr_hit && !fault_hit |=> o_threshold_code == $past(q.thresh))
        else $error("threshold changed by supply drop");
    // flash key resets the device
    flash_key_a: assert property (iap_hit && q.st == RSC_ST_RUN |=> o_dev_reset)
        else $error("flash key reset missing");
    // running expiry is a full reset with expiry flag
    wdt_run_a: assert property (wdt_run && q.st == RSC_ST_RUN
        |=> o_dev_reset && o_wdt_expiry_flag && o_init.port_in)
        else $error("running watchdog reset wrong");
    // sleeping expiry only restarts pc and sp
    wdt_low_a: assert property (wdt_low && !full_req && q.st == RSC_ST_RUN |=> o_init.pc_zero
        && !o_dev_reset && !o_init.port_in && o_wdt_expiry_flag && o_powerdown_flag)
        else $error("sleeping watchdog reset wrong");
    // pin reset leaves status flags alone
    pin_flags_a: assert property (i_pin_clear && !i_wdt_expiry
        |=> $stable(o_wdt_expiry_flag) && $stable(o_powerdown_flag))
        else $error("status flags disturbed");
    // guard fault sets its flag
    guard_flag_a: assert property (i_guard_fault && q.st == RSC_ST_RUN |=> q.cause[3])
        else $error("guard fault flag not set");
    // cause register upper bits read zero
    rsv_zero_a: assert property ($rose(o_ahb.hreadyout) && $past(!q.ahb_wr)
        && $past(q.ahb_addr) == 8'h04 |-> o_ahb.hrdata[31:4] == 28'h0)
        else $error("reserved cause bits not zero");
    // interrupt tracks enabled status
    irq_lvl_a: assert property (o_irq == |(q.irq_stat & q.irq_en))
        else $error("interrupt level wrong");

    supply_cov_c: cover property (lvr_hit ##1 o_dev_reset);
    fault_cov_c:  cover property (fault_hit ##1 o_dev_reset);
    sleep_cov_c:  cover property (wdt_low ##1 o_init.pc_zero);
    key_cov_c:    cover property (iap_hit ##3 !o_dev_reset);

endmodule // rsc_top

// ==== include/rsc_cfg.svh ====
// rsc_cfg.svh: offsets, field positions, reset values and timing counts
// assumes inclusion by bare name; definitions only
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH
`define RSC_OFF_THRESH   8'h00
`define RSC_OFF_CAUSE    8'h04
`define RSC_OFF_STATUS   8'h08
`define RSC_OFF_FLASH1   8'h0c
`define RSC_OFF_IRQ_STAT 8'h10
`define RSC_OFF_IRQ_CLR  8'h14
`define RSC_OFF_IRQ_EN   8'h18
`define RSC_THRESH_POR   8'h55
`define RSC_CODE_2V10    8'h55
`define RSC_CODE_2V55    8'h33
`define RSC_CODE_3V15    8'h99
`define RSC_CODE_3V80    8'haa
`define RSC_IAP_KEY      8'h55
`define RSC_BIT_WDCODE   0
`define RSC_BIT_LRF      1
`define RSC_BIT_SUPPLY_DROP_CAUSE_FLAG     2
`define RSC_BIT_CONTROL_CODE_FAULT_FLAG     3
`define RSC_NUM_EV       5
`define RSC_CNT_W        16
`define RSC_CLK_KHZ      20000
`define RSC_FILTER_NS    120000
`define RSC_FAULT_NS     50000
`define RSC_FILTER_CYC   ((`RSC_FILTER_NS / 1000) * `RSC_CLK_KHZ / 1000)
`define RSC_FAULT_CYC    ((`RSC_FAULT_NS / 1000) * `RSC_CLK_KHZ / 1000)
`define RSC_HOLD_CYC     2
`endif

// ==== include/rsc_pkg.sv ====
// rsc_pkg: types shared by the reset source control block
// assumes rsc_cfg.svh is on the include path
`include "rsc_cfg.svh"
package rsc_pkg;
    // sequencer states, one-hot
    typedef enum logic [1:0] {
        RSC_ST_RUN  = 2'b01,
        RSC_ST_HOLD = 2'b10
    } rsc_state_t;
    // cpu power mode reported by the clock controller
    typedef enum logic [1:0] {
        RSC_PM_FAST  = 2'b00,
        RSC_PM_SLOW  = 2'b01,
        RSC_PM_IDLE  = 2'b10,
        RSC_PM_SLEEP = 2'b11
    } rsc_pwr_mode_t;
    // ahb-lite request side
    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
        logic [31:0] hwdata;
    } rsc_ahb_req_t;
    // ahb-lite response side
    typedef struct packed {
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        hresp;
    } rsc_ahb_rsp_t;
    // initial conditions applied to the rest of the chip
    typedef struct packed {
        logic pc_zero;
        logic sp_reset;
        logic irq_off;
        logic wdt_restart;
        logic tmr_off;
        logic port_in;
    } rsc_init_t;
endpackage

// ==== testbench/rsc_top_tb.sv ====
// rsc_top_tb: self-checking bench for the reset source control block
// assumes rsc_pkg and rsc_cfg.svh are compiled first; the bench is the only bus master
`timescale 1ns/1ns
`include "rsc_cfg.svh"
module rsc_top_tb;
    import rsc_pkg::*;
    localparam int unsigned FILT = 4; // shortened supply drop filter
    localparam int unsigned FLT  = 3; // shortened code fault delay
    logic          i_clk_sys = 1'b0;
    logic          i_resetn = 1'b0;
    logic          i_ce = 1'b1;
    logic          hsel = 1'b0;
    logic          hwrite = 1'b0;
    logic [1:0]    htrans = 2'h0;
    logic [31:0]   haddr = 32'h0;
    logic [31:0]   hwdata = 32'h0;
    rsc_ahb_req_t  i_ahb;
    rsc_ahb_rsp_t  o_ahb;
    logic          i_supply_low = 1'b0;
    rsc_pwr_mode_t i_pwr_mode = RSC_PM_FAST;
    logic          i_pin_clear = 1'b0;
    logic          i_wdt_expiry = 1'b0;
    logic          i_wdt_code_fault = 1'b0;
    logic          i_guard_fault = 1'b0;
    logic          o_dev_reset;
    rsc_init_t     o_init;
    logic          o_monitor_en;
    logic [7:0]    o_threshold_code;
    logic          o_wdt_expiry_flag;
    logic          o_powerdown_flag;
    logic          o_irq;
    int            miscompares = 0; // failed compares
    int            tests_run = 0;   // all compares
    int            rst_count = 0;   // rising edges of the device reset
    logic          rst_prev = 1'b0;
    logic [31:0]   rd;
    logic [7:0]    codes [4] = '{8'h55, 8'h33, 8'h99, 8'haa}; // the four legal thresholds
    // hready loops back from the one slave
    assign i_ahb = '{hsel: hsel, haddr: haddr, htrans: htrans, hwrite: hwrite,
                     hsize: 3'h2, hready: o_ahb.hreadyout, hwdata: hwdata};
    rsc_top #(.FILTER_CYC(FILT), .FAULT_CYC(FLT)) dut (
        .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_ce(i_ce), .i_ahb(i_ahb),
        .i_supply_low(i_supply_low), .i_pwr_mode(i_pwr_mode), .i_pin_clear(i_pin_clear),
        .i_wdt_expiry(i_wdt_expiry), .i_wdt_code_fault(i_wdt_code_fault),
        .i_guard_fault(i_guard_fault), .o_ahb(o_ahb), .o_dev_reset(o_dev_reset),
        .o_init(o_init), .o_monitor_en(o_monitor_en), .o_threshold_code(o_threshold_code),
        .o_wdt_expiry_flag(o_wdt_expiry_flag), .o_powerdown_flag(o_powerdown_flag),
        .o_irq(o_irq));
    // 20 mhz clock
    always #25 i_clk_sys = ~i_clk_sys;
    // counts reset pulses so quiet windows can be judged afterwards
    always @(posedge i_clk_sys) begin
        if (o_dev_reset === 1'b1 && rst_prev !== 1'b1) rst_count++;
        rst_prev = o_dev_reset;
    end
    // verdict, reached from the main sequence or the watchdog
    task automatic complete_run;
        $display("tests_run %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // compare with case equality so unknowns never match
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // one single ahb-lite transfer; entered just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge i_clk_sys); while (o_ahb.hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge i_clk_sys); while (o_ahb.hreadyout !== 1'b1);
        r = o_ahb.hrdata;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string m);
        bus(1'b0, a, 32'h0, rd);
        chk(rd, exp, m);
        chk(o_ahb.hresp, 0, "error response");
    endtask
    // waits for a full reset, checks its initial conditions, waits for its end
    task automatic wait_rst(input int lim);
        int n;
        n = 0;
        while (o_dev_reset !== 1'b1 && n < lim) begin
            @(posedge i_clk_sys);
            n++;
        end
        chk(o_dev_reset, 1, "device reset missing");
        chk(o_init, 6'h3f, "full reset initial conditions");
        n = 0;
        while (o_dev_reset !== 1'b0 && n < 10) begin
            @(posedge i_clk_sys);
            n++;
        end
        chk(o_dev_reset, 0, "device reset stuck");
    endtask
    // power-on: all initial conditions, register reset values
    task automatic t_power_on;
        repeat (5) @(posedge i_clk_sys);
        chk(o_init, 6'h3f, "power-on initial conditions");
        i_resetn <= 1'b1;
        wait_rst(3);
        rdchk(`RSC_OFF_THRESH, 32'h55, "threshold power-on value");
        rdchk(`RSC_OFF_CAUSE, 32'h0, "cause flags at power-on");
        rdchk(`RSC_OFF_STATUS, 32'h0, "status flags at power-on");
        rdchk(8'h40, 32'h0, "unmapped read");
    endtask
    // legal codes never reset; short drops and drops in idle are ignored
    task automatic t_quiet;
        int c0;
        c0 = rst_count;
        foreach (codes[i]) begin
            bus(1'b1, `RSC_OFF_THRESH, {24'h0, codes[i]}, rd);
            repeat (FLT + 4) @(posedge i_clk_sys);
            chk(o_threshold_code, codes[i], "threshold code readback");
        end
        i_supply_low <= 1'b1;
        repeat (FILT) @(posedge i_clk_sys);
        i_supply_low <= 1'b0;
        repeat (8) @(posedge i_clk_sys);
        i_pwr_mode <= RSC_PM_IDLE;
        repeat (2) @(posedge i_clk_sys);
        chk(o_monitor_en, 0, "monitor on in idle");
        i_supply_low <= 1'b1;
        repeat (FILT + 8) @(posedge i_clk_sys);
        i_supply_low <= 1'b0;
        i_pwr_mode <= RSC_PM_FAST;
        repeat (3) @(posedge i_clk_sys);
        chk(rst_count - c0, 0, "spurious reset");
    endtask
    // genuine drop: reset, flag bit 2, threshold kept, software-only clear
    task automatic t_drop;
        bus(1'b1, `RSC_OFF_THRESH, 32'h33, rd);
        i_supply_low <= 1'b1;
        wait_rst(FILT + 6);
        i_supply_low <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        rdchk(`RSC_OFF_THRESH, 32'h33, "threshold lost on drop reset");
        bus(1'b1, `RSC_OFF_CAUSE, 32'hff, rd);
        rdchk(`RSC_OFF_CAUSE, 32'h04, "drop flag after write one");
        bus(1'b1, `RSC_OFF_CAUSE, 32'h0, rd);
        rdchk(`RSC_OFF_CAUSE, 32'h0, "drop flag clear");
    endtask
    // undefined code: reset after the fault delay, power-on value, flag bit 1
    task automatic t_bad_code;
        bus(1'b1, `RSC_OFF_THRESH, 32'h12, rd);
        wait_rst(FLT + 6);
        rdchk(`RSC_OFF_THRESH, 32'h55, "threshold not restored");
        rdchk(`RSC_OFF_CAUSE, 32'h02, "code fault flag");
        bus(1'b1, `RSC_OFF_CAUSE, 32'h0, rd);
        rdchk(`RSC_OFF_CAUSE, 32'h0, "code fault flag clear");
    endtask
    // full reset sources: flash key, pin, watchdog code, guard, watchdog expiry
    task automatic t_sources;
        for (int k = 0; k < 5; k++) begin
            bus(1'b1, `RSC_OFF_THRESH, 32'haa, rd);
            case (k)
                0: bus(1'b1, `RSC_OFF_FLASH1, 32'h55, rd);
                1: i_pin_clear <= 1'b1;
                2: i_wdt_code_fault <= 1'b1;
                3: i_guard_fault <= 1'b1;
                default: i_wdt_expiry <= 1'b1;
            endcase
            @(posedge i_clk_sys);
            i_pin_clear <= 1'b0;
            i_wdt_code_fault <= 1'b0;
            i_guard_fault <= 1'b0;
            i_wdt_expiry <= 1'b0;
            wait_rst(4);
            rdchk(`RSC_OFF_THRESH, 32'h55, "threshold after full reset");
        end
        rdchk(`RSC_OFF_CAUSE, 32'h09, "guard and watchdog code flags");
        rdchk(`RSC_OFF_STATUS, 32'h01, "expiry flag only");
        chk({o_powerdown_flag, o_wdt_expiry_flag}, 2'h1, "expiry flag outputs");
        bus(1'b1, `RSC_OFF_STATUS, 32'h0, rd);
        rdchk(`RSC_OFF_STATUS, 32'h01, "status writable");
    endtask
    // watchdog expiry asleep: pc and sp only, both flags, interrupt path
    task automatic t_sleep_wdt;
        int n;
        bus(1'b1, `RSC_OFF_IRQ_CLR, 32'h1f, rd);
        bus(1'b1, `RSC_OFF_IRQ_EN, 32'h08, rd);
        rdchk(`RSC_OFF_IRQ_STAT, 32'h0, "irq status after clear");
        chk(o_irq, 0, "irq idle");
        i_pwr_mode <= RSC_PM_SLEEP;
        i_wdt_expiry <= 1'b1;
        @(posedge i_clk_sys);
        i_wdt_expiry <= 1'b0;
        n = 0;
        while (o_init.pc_zero !== 1'b1 && n < 4) begin
            @(posedge i_clk_sys);
            n++;
        end
        chk(o_init, 6'h30, "sleep expiry initial conditions");
        chk(o_dev_reset, 0, "full reset in sleep expiry");
        repeat (4) @(posedge i_clk_sys);
        i_pwr_mode <= RSC_PM_FAST;
        rdchk(`RSC_OFF_STATUS, 32'h03, "both status flags");
        chk({o_powerdown_flag, o_wdt_expiry_flag}, 2'h3, "status flag outputs");
        chk(o_irq, 1, "irq not raised");
        rdchk(`RSC_OFF_IRQ_STAT, 32'h08, "irq status expiry bit");
        bus(1'b1, `RSC_OFF_IRQ_EN, 32'h0, rd);
        @(posedge i_clk_sys);
        chk(o_irq, 0, "irq not masked");
        bus(1'b1, `RSC_OFF_IRQ_EN, 32'h08, rd);
        bus(1'b1, `RSC_OFF_IRQ_CLR, 32'h08, rd);
        @(posedge i_clk_sys);
        chk(o_irq, 0, "irq not cleared");
        rdchk(`RSC_OFF_IRQ_STAT, 32'h0, "irq status not cleared");
    endtask
    // clock enable low freezes all state: a long drop and an expiry pass unseen
    task automatic t_freeze;
        int c0;
        c0 = rst_count;
        i_ce <= 1'b0;
        i_supply_low <= 1'b1;
        i_wdt_expiry <= 1'b1;
        repeat (FILT + 4) @(posedge i_clk_sys);
        i_supply_low <= 1'b0;
        i_wdt_expiry <= 1'b0;
        @(posedge i_clk_sys);
        i_ce <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        chk(rst_count - c0, 0, "state moved while frozen");
        chk(o_irq, 0, "irq raised while frozen");
    endtask
    // watchdog against a hung wait
    initial begin
        #(50 * 5000);
        miscompares++;
        $display("mismatch %0t timeout", $time);
        complete_run();
    end
    // main sequence
    initial begin
        t_power_on();
        t_quiet();
        t_drop();
        t_bad_code();
        t_sources();
        t_sleep_wdt();
        t_freeze();
        complete_run();
    end
endmodule // rsc_top_tb
